// >>> hdl/vst_map.svh
// vst_map.svh: offsets, field positions, reset values and timing counts
// for the voltage-id soft transient sequencer.
// assumes a 100 MHz core clock; included by bare name.
//
// How it works
// - ramp-pulse mode normally; fixed-clock pwm in soft-start, transient, overload
// - pwm held for 100 us after every id code change accepted in the run state
// - a new id code is ignored for at least 400 ns
// - dac target walks one code at a time toward the final code
// - one dac step every 0.5 us, 25 mV per step
// - at power-up the dac walks through every code up to the programmed one
// - power-good failure hidden during soft-start and after any code change
// - power-good mask lasts about 100 us from an internal counter
// - each code change clears and restarts the mask counter
// - mask held 100 us after the last dac step of a transient
// - unmasked, output good high inside -300 mV..+200 mV of target
// - ramp-pulse mode: comp above threshold sets high side, starts ramp
// - ramp-pulse mode: ramp reaching comp clears the high side request
// - disabled or undervoltage: gates low, sequencing reset, output good low
`ifndef VST_MAP_SVH
`define VST_MAP_SVH

`define VST_CLK_NS       10
`define VST_FILT_NS      400
`define VST_STEP_NS      500
`define VST_MASK_US      100
`define VST_PWM_NS       2000
`define VST_STEP_MV      25

`define VST_FILT_CYC ((`VST_FILT_NS + `VST_CLK_NS - 1) / `VST_CLK_NS)
`define VST_STEP_CYC (`VST_STEP_NS / `VST_CLK_NS)
`define VST_MASK_CYC (`VST_MASK_US * 1000 / `VST_CLK_NS)
`define VST_PWM_CYC  (`VST_PWM_NS / `VST_CLK_NS)

`define VST_START_CODE   5'h1F

`define VST_ADDR_STATUS  8'h00
`define VST_ADDR_IRQ_EN  8'h04
`define VST_ADDR_IRQ_CLR 8'h08
`define VST_ADDR_CTRL    8'h0C
`define VST_ADDR_STATE   8'h10

`define VST_EV_ACCEPT    0
`define VST_EV_SS_DONE   1
`define VST_EV_PG_FALL   2
`define VST_EV_OVL       3
`define VST_EV_N         4

`define VST_CTRL_FORCE_PWM 0
`define VST_CTRL_RESET     1'h0

`define VST_ST_TARGET_LSB  8
`define VST_ST_PWM         16
`define VST_ST_MASKED      17
`define VST_ST_GOOD        18
`define VST_ST_PG_PIN      19
`define VST_ST_STATE_LSB   20

`endif

// >>> hdl/vst_pkg.sv
// vst_pkg: types shared by the sequencer files.
// assumes vst_map.svh for the numeric constants.
package vst_pkg;
	typedef logic [4:0] vst_code_t;

	typedef enum logic [1:0] {
		VST_OFF  = 2'b00,
		VST_SOFT = 2'b01,
		VST_RUN  = 2'b10
	} vst_state_e;
endpackage : vst_pkg

// >>> hdl/vst_pin_sync.sv
// vst_pin_sync: three-flop input filter for asynchronous pins.
// assumes inputs may change at any time; output follows once stable.
`timescale 1ns/100ps
module vst_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_nxt;

	// a bit moves only when the last two stages agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q    <= '0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q    <= q_nxt;
		end
	end
endmodule : vst_pin_sync

// >>> hdl/vst_sequencer.sv
// vst_sequencer: digital control of a single-phase buck controller.
// assumes analog comparators arrive as asynchronous levels and a simple
// register port with read data one cycle after the read strobe.
`timescale 1ns/100ps
`include "vst_map.svh"
module vst_sequencer
	import vst_pkg::*;
#(
	parameter logic [13:0] MASK_CYC = 14'(`VST_MASK_CYC)
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        enable_pin,
	input  wire logic        supply_ok,
	input  wire logic [4:0]  voltage_id_code,
	input  wire logic        overload_flag,
	input  wire logic        comp_above_thresh,
	input  wire logic        ramp_reached_comp,
	input  wire logic        vout_above_low,
	input  wire logic        vout_below_high,
	input  wire logic        output_good_in,
	output logic             output_good_out,
	output logic             output_good_oe_n,
	output logic             high_side_gate_request,
	output logic             low_side_gate_request,
	output logic             ramp_start,
	output logic             ramp_pulse_mode,
	output vst_code_t        dac_code,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq
);
	localparam logic [5:0] FILT_CYC = 6'(`VST_FILT_CYC);
	localparam logic [5:0] STEP_CYC = 6'(`VST_STEP_CYC);
	localparam logic [7:0] PWM_CYC  = 8'(`VST_PWM_CYC);

	// synchronised pins
	logic [12:0] pins_s;
	logic        en_s;
	logic        vcc_s;
	vst_code_t   code_s;
	logic        ovl_s;
	logic        comp_hi_s;
	logic        ramp_hit_s;
	logic        lo_ok_s;
	logic        hi_ok_s;
	logic        pg_pin_s;

	vst_pin_sync #(
		.W (13)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.pin ({output_good_in, vout_below_high, vout_above_low,
		       ramp_reached_comp, comp_above_thresh, overload_flag,
		       voltage_id_code, supply_ok, enable_pin}),
		.q   (pins_s)
	);

	assign en_s       = pins_s[0];
	assign vcc_s      = pins_s[1];
	assign code_s     = pins_s[6:2];
	assign ovl_s      = pins_s[7];
	assign comp_hi_s  = pins_s[8];
	assign ramp_hit_s = pins_s[9];
	assign lo_ok_s    = pins_s[10];
	assign hi_ok_s    = pins_s[11];
	assign pg_pin_s   = pins_s[12];

	logic chip_on;
	assign chip_on = en_s & vcc_s;

	// code filter
	vst_code_t  last_r;
	vst_code_t  last_nxt;
	vst_code_t  target_r;
	vst_code_t  target_nxt;
	logic [5:0] filt_r;
	logic [5:0] filt_nxt;
	logic       accept;

	always_comb begin
		last_nxt   = last_r;
		filt_nxt   = filt_r;
		target_nxt = target_r;
		accept     = 1'b0;
		if (code_s != last_r) begin
			// skewed bits keep restarting the wait
			last_nxt = code_s;
			filt_nxt = FILT_CYC;
		end else if (filt_r != 6'h00) begin
			filt_nxt = filt_r - 6'h01;
			if (filt_r == 6'h01 && last_r != target_r) begin
				target_nxt = last_r;
				accept     = chip_on;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			last_r   <= 5'h00;
			filt_r   <= 6'h00;
			target_r <= 5'h00;
		end else begin
			last_r   <= last_nxt;
			filt_r   <= filt_nxt;
			target_r <= target_nxt;
		end
	end

	// sequencing: soft-start, dac walk, mask and pwm window
	vst_state_e  state_r;
	vst_state_e  state_nxt;
	vst_code_t   dac_nxt;
	logic [5:0]  step_r;
	logic [5:0]  step_nxt;
	logic [13:0] mask_r;
	logic [13:0] mask_nxt;
	logic [13:0] win_r;
	logic [13:0] win_nxt;
	logic        step_ev;
	logic        ss_done;

	always_comb begin
		state_nxt = state_r;
		dac_nxt   = dac_code;
		step_nxt  = step_r;
		mask_nxt  = (mask_r != 14'h0000) ? mask_r - 14'h0001 : mask_r;
		win_nxt   = (win_r != 14'h0000) ? win_r - 14'h0001 : win_r;
		step_ev   = 1'b0;
		ss_done   = 1'b0;
		if (state_r != VST_OFF && dac_code != target_r) begin
			if (step_r == 6'h00) begin
				step_ev  = 1'b1;
				step_nxt = STEP_CYC - 6'h01;
				// larger code is lower voltage
				if (target_r > dac_code)
					dac_nxt = dac_code + 5'h01;
				else
					dac_nxt = dac_code - 5'h01;
			end else begin
				step_nxt = step_r - 6'h01;
			end
		end else begin
			step_nxt = STEP_CYC - 6'h01;
		end
		unique case (state_r)
			VST_OFF: begin
				dac_nxt  = `VST_START_CODE;
				mask_nxt = 14'h0000;
				win_nxt  = 14'h0000;
				if (chip_on)
					state_nxt = VST_SOFT;
			end
			VST_SOFT: begin
				if (dac_code == target_r) begin
					state_nxt = VST_RUN;
					ss_done   = 1'b1;
					mask_nxt  = MASK_CYC;
				end
			end
			VST_RUN: begin
				if (accept || step_ev) begin
					mask_nxt = MASK_CYC;
					win_nxt  = MASK_CYC;
				end
			end
			default: state_nxt = VST_OFF;
		endcase
		if (!chip_on)
			state_nxt = VST_OFF;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r  <= VST_OFF;
			dac_code <= `VST_START_CODE;
			step_r   <= 6'h00;
			mask_r   <= 14'h0000;
			win_r    <= 14'h0000;
		end else begin
			state_r  <= state_nxt;
			dac_code <= dac_nxt;
			step_r   <= step_nxt;
			mask_r   <= mask_nxt;
			win_r    <= win_nxt;
		end
	end

	// power good and mode
	logic ctrl_r;
	logic ctrl_nxt;
	logic masked;
	logic pwm_mode;
	logic good_r;
	logic good_nxt;
	logic pg_fall;

	assign masked = (state_r == VST_SOFT) || (mask_r != 14'h0000);
	assign pwm_mode = ctrl_r || state_r == VST_SOFT || win_r != 14'h0000
	                  || dac_code != target_r || ovl_s;

	always_comb begin
		good_nxt = good_r;
		if (state_r != VST_RUN)
			good_nxt = 1'b0;
		else if (!masked)
			good_nxt = lo_ok_s & hi_ok_s;
		pg_fall = good_r & ~good_nxt;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			good_r <= 1'b0;
		else
			good_r <= good_nxt;
	end

	// open-drain: pull low unless good
	assign output_good_out  = 1'b0;
	assign output_good_oe_n = good_r;

	// gate requests
	logic [7:0] per_r;
	logic [7:0] per_nxt;
	logic       hs_nxt;
	logic       ls_nxt;
	logic       rs_nxt;
	logic       rpm_nxt;

	always_comb begin
		per_nxt = (per_r == 8'h00) ? PWM_CYC - 8'h01 : per_r - 8'h01;
		hs_nxt  = high_side_gate_request;
		rs_nxt  = 1'b0;
		if (state_r == VST_OFF) begin
			hs_nxt = 1'b0;
		end else if (high_side_gate_request) begin
			if (ramp_hit_s)
				hs_nxt = 1'b0;
		end else if (pwm_mode ? per_r == 8'h00 : comp_hi_s) begin
			hs_nxt = 1'b1;
			rs_nxt = 1'b1;
		end
		ls_nxt  = (state_r != VST_OFF) & ~hs_nxt;
		rpm_nxt = (state_r != VST_OFF) & ~pwm_mode;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			per_r                  <= 8'h00;
			high_side_gate_request <= 1'b0;
			low_side_gate_request  <= 1'b0;
			ramp_start             <= 1'b0;
			ramp_pulse_mode        <= 1'b0;
		end else begin
			per_r                  <= per_nxt;
			high_side_gate_request <= hs_nxt;
			low_side_gate_request  <= ls_nxt;
			ramp_start             <= rs_nxt;
			ramp_pulse_mode        <= rpm_nxt;
		end
	end

	// registers and interrupt
	logic                 ovl_d_r;
	logic [`VST_EV_N-1:0] ev;
	logic [`VST_EV_N-1:0] stat_r;
	logic [`VST_EV_N-1:0] stat_nxt;
	logic [`VST_EV_N-1:0] ien_r;
	logic [`VST_EV_N-1:0] ien_nxt;
	logic [`VST_EV_N-1:0] clr;
	logic [31:0]          rd_nxt;

	always_comb begin
		ev                    = '0;
		ev[`VST_EV_ACCEPT]    = accept;
		ev[`VST_EV_SS_DONE]   = ss_done;
		ev[`VST_EV_PG_FALL]   = pg_fall;
		ev[`VST_EV_OVL]       = ovl_s & ~ovl_d_r & (state_r != VST_OFF);
		clr = '0;
		if (reg_wr && reg_addr == `VST_ADDR_IRQ_CLR)
			clr = reg_wdata[`VST_EV_N-1:0];
		// a new event beats a clear in the same cycle
		stat_nxt = (stat_r & ~clr) | ev;
		ien_nxt  = ien_r;
		ctrl_nxt = ctrl_r;
		if (reg_wr && reg_addr == `VST_ADDR_IRQ_EN)
			ien_nxt = reg_wdata[`VST_EV_N-1:0];
		if (reg_wr && reg_addr == `VST_ADDR_CTRL)
			ctrl_nxt = reg_wdata[`VST_CTRL_FORCE_PWM];
		rd_nxt = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				`VST_ADDR_STATUS: rd_nxt[`VST_EV_N-1:0] = stat_r;
				`VST_ADDR_IRQ_EN: rd_nxt[`VST_EV_N-1:0] = ien_r;
				`VST_ADDR_CTRL:   rd_nxt[`VST_CTRL_FORCE_PWM] = ctrl_r;
				`VST_ADDR_STATE: begin
					rd_nxt[4:0] = dac_code;
					rd_nxt[`VST_ST_TARGET_LSB +: 5] = target_r;
					rd_nxt[`VST_ST_PWM]    = pwm_mode;
					rd_nxt[`VST_ST_MASKED] = masked;
					rd_nxt[`VST_ST_GOOD]   = good_r;
					rd_nxt[`VST_ST_PG_PIN] = pg_pin_s;
					rd_nxt[`VST_ST_STATE_LSB +: 2] = state_r;
				end
				default: rd_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovl_d_r   <= 1'b0;
			stat_r    <= '0;
			ien_r     <= '0;
			ctrl_r    <= `VST_CTRL_RESET;
			reg_rdata <= 32'h0000_0000;
		end else begin
			ovl_d_r   <= ovl_s;
			stat_r    <= stat_nxt;
			ien_r     <= ien_nxt;
			ctrl_r    <= ctrl_nxt;
			reg_rdata <= rd_nxt;
		end
	end

	assign irq = |(stat_r & ien_r);
endmodule : vst_sequencer

// >>> test/vst_sequencer_properties.sv
// vst_sequencer_properties: port-level timing checks of the sequencer.
// assumes the bind below and one clean core clock.
`timescale 1ns/100ps
module vst_seq_checker
	import vst_pkg::*;
#(
	parameter logic [13:0] MASK_CYC = 14'h2710
) (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       enable_pin,
	input wire logic       supply_ok,
	input wire logic [4:0] voltage_id_code,
	input wire logic       overload_flag,
	input wire logic       comp_above_thresh,
	input wire logic       ramp_reached_comp,
	input wire logic       output_good_oe_n,
	input wire logic       high_side_gate_request,
	input wire logic       low_side_gate_request,
	input wire logic       ramp_start,
	input wire logic       ramp_pulse_mode,
	input wire vst_code_t  dac_code
);
	logic [3:0]  on_cnt;
	logic [5:0]  step_cnt;
	logic [15:0] vid_cnt;
	logic        on8;
	logic        in_win;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// dac jumps home on shutdown, so step checks wait for a settled enable
	assign on8 = on_cnt == 4'h8;
	assign in_win = on8 && vid_cnt >= 16'h003C && vid_cnt < {2'h0, MASK_CYC};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			on_cnt   <= 4'h0;
			step_cnt <= 6'h3F;
			vid_cnt  <= 16'hFFFF;
		end else begin
			on_cnt   <= !(enable_pin && supply_ok) ? 4'h0 : on_cnt + {3'h0, !on8};
			step_cnt <= $changed(dac_code) ? 6'h00
				: step_cnt + {5'h00, step_cnt != 6'h3F};
			vid_cnt  <= $changed(voltage_id_code) ? 16'h0000
				: vid_cnt + {15'h0000, vid_cnt != 16'hFFFF};
		end
	end

	property p_step_one;
		$changed(dac_code) && on8 |-> dac_code == $past(dac_code) + 5'h01
			|| dac_code == $past(dac_code) - 5'h01;
	endproperty
	a_step_one: assert property (p_step_one)
		else $error("dac moved by more than one code");

	property p_step_gap;
		$changed(dac_code) && on8 |-> step_cnt >= 6'h31;
	endproperty
	a_step_gap: assert property (p_step_gap)
		else $error("dac steps closer than 50 cycles");

	property p_pwm_window;
		in_win |-> !ramp_pulse_mode;
	endproperty
	a_pwm_window: assert property (p_pwm_window)
		else $error("ramp-pulse mode inside the transient window");

	property p_pg_frozen;
		in_win |-> $stable(output_good_oe_n);
	endproperty
	a_pg_frozen: assert property (p_pg_frozen)
		else $error("output good moved while masked");

	property p_off;
		(!enable_pin)[*7] |-> !high_side_gate_request
			&& !low_side_gate_request && !output_good_oe_n && !ramp_pulse_mode;
	endproperty
	a_off: assert property (p_off)
		else $error("outputs active while disabled");

	property p_hs_set;
		$rose(comp_above_thresh) && ramp_pulse_mode
			|-> ##[1:7] high_side_gate_request;
	endproperty
	a_hs_set: assert property (p_hs_set)
		else $error("high side not set by comparator");

	property p_ramp_start;
		$rose(high_side_gate_request) |-> ##[0:1] ramp_start;
	endproperty
	a_ramp_start: assert property (p_ramp_start)
		else $error("ramp not started with high side");

	property p_hs_clear;
		$rose(ramp_reached_comp) |-> ##[1:7] !high_side_gate_request;
	endproperty
	a_hs_clear: assert property (p_hs_clear)
		else $error("high side not cleared by ramp");

	property p_overload;
		overload_flag[*6] |-> !ramp_pulse_mode;
	endproperty
	a_overload: assert property (p_overload)
		else $error("ramp-pulse mode during overload");

	c_step: cover property ($changed(dac_code) && on8);
	c_win: cover property (in_win && vid_cnt == 16'h0064);
	c_rpm: cover property ($rose(high_side_gate_request) && ramp_pulse_mode);
endmodule : vst_seq_checker

bind vst_sequencer vst_seq_checker #(.MASK_CYC(MASK_CYC)) i_vst_seq_checker (
	.clk, .rst, .enable_pin, .supply_ok, .voltage_id_code, .overload_flag,
	.comp_above_thresh, .ramp_reached_comp, .output_good_oe_n,
	.high_side_gate_request, .low_side_gate_request, .ramp_start,
	.ramp_pulse_mode, .dac_code
);

// >>> test/vst_chipset_model.sv
// vst_chipset_model: chipset end of the id code link.
// assumes the bench names the wanted code; bits settle with skew.
`timescale 1ns/100ps
module vst_chipset_model (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [4:0] want,
	output logic     [4:0] voltage_id_code
);
	logic [4:0] diff;

	assign diff = want ^ voltage_id_code;

	// one bit per edge, so in-between codes show up as real skew
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			voltage_id_code <= 5'h1C;
		end else begin
			voltage_id_code <= voltage_id_code ^ (diff & (~diff + 5'h01));
		end
	end
endmodule : vst_chipset_model

// >>> test/vst_sequencer_tb_top.sv
// vst_sequencer_tb_top: self-checking bench for the sequencer.
// assumes ideal analog levels; the ramp ends one cycle after high side.
`timescale 1ns/100ps
`include "vst_map.svh"
module vst_sequencer_tb_top
	import vst_pkg::*;
;

	localparam logic [13:0] MC = 14'h00C8;
	logic        clk, rst, enable_pin, supply_ok, overload_flag;
	logic        comp_above_thresh, ramp_reached_comp;
	logic        vout_above_low, vout_below_high, output_good_out;
	logic        output_good_oe_n, high_side_gate_request;
	logic        low_side_gate_request, ramp_start, ramp_pulse_mode, irq;
	logic        reg_wr, reg_rd;
	logic [4:0]  want, voltage_id_code;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	vst_code_t   dac_code;
	wire logic   pg_pin;
	int          bad_count, tests_run, cyc, rs_cnt, n;

	// open-drain pin with a pull-up
	assign pg_pin = output_good_oe_n ? 1'b1 : output_good_out;

	vst_sequencer #(.MASK_CYC(MC)) i_vst_sequencer (
		.clk, .rst, .enable_pin, .supply_ok, .voltage_id_code, .overload_flag,
		.comp_above_thresh, .ramp_reached_comp, .vout_above_low,
		.vout_below_high, .output_good_in(pg_pin), .output_good_out,
		.output_good_oe_n, .high_side_gate_request, .low_side_gate_request,
		.ramp_start, .ramp_pulse_mode, .dac_code, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .irq
	);
	vst_chipset_model i_vst_chipset_model (.clk, .rst, .want, .voltage_id_code);

	task automatic chk(input string what, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	task automatic wrap_up;
		if (bad_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	task automatic t_start;
		tick(60);
		chk("mode", 32'h0, 32'(ramp_pulse_mode));
		chk("good", 32'h0, 32'(output_good_oe_n));
		tick(200);
		chk("dac", 32'h1C, 32'(dac_code));
		rd(`VST_ADDR_STATE);
		chk("state", 32'h2, 32'(v[21:20]));
		chk("irq", 32'h0, 32'(irq));
		wr(`VST_ADDR_IRQ_EN, 32'h2);
		tick(1);
		chk("irq", 32'h1, 32'(irq));
		wr(`VST_ADDR_IRQ_CLR, 32'hF);
		tick(1);
		chk("irq", 32'h0, 32'(irq));
		rd(8'h3C);
		chk("unmapped", 32'h0, v);
	endtask : t_start

	task automatic t_good;
		tick(150);
		chk("mode", 32'h1, 32'(ramp_pulse_mode));
		chk("good", 32'h1, 32'(output_good_oe_n));
		@(posedge clk) vout_below_high <= 1'b0;
		tick(8);
		chk("good", 32'h0, 32'(output_good_oe_n));
		chk("pin", 32'h0, 32'(pg_pin));
		@(posedge clk) vout_below_high <= 1'b1;
		tick(8);
		chk("good", 32'h1, 32'(output_good_oe_n));
	endtask : t_good

	task automatic t_rpm;
		n = rs_cnt;
		@(posedge clk);
		comp_above_thresh <= 1'b1;
		repeat (3) @(posedge clk);
		comp_above_thresh <= 1'b0;
		tick(20);
		chk("starts", 32'(n + 1), 32'(rs_cnt));
		chk("high", 32'h0, 32'(high_side_gate_request));
	endtask : t_rpm

	task automatic t_move;
		@(posedge clk);
		want <= 5'h19;
		repeat (60) @(posedge clk);
		vout_above_low <= 1'b0;
		chk("mode", 32'h0, 32'(ramp_pulse_mode));
		tick(240);
		chk("dac", 32'h19, 32'(dac_code));
		chk("good", 32'h1, 32'(output_good_oe_n));
		tick(120);
		chk("good", 32'h0, 32'(output_good_oe_n));
		chk("mode", 32'h1, 32'(ramp_pulse_mode));
		@(posedge clk) vout_above_low <= 1'b1;
		tick(10);
		@(posedge clk) want <= 5'h1E;
		tick(110);
		@(posedge clk) want <= 5'h17;
		tick(500);
		chk("dac", 32'h17, 32'(dac_code));
	endtask : t_move

	task automatic t_ovl;
		wr(`VST_ADDR_IRQ_CLR, 32'hF);
		overload_flag <= 1'b1;
		tick(8);
		chk("mode", 32'h0, 32'(ramp_pulse_mode));
		@(posedge clk) want <= 5'h03;
		repeat (10) @(posedge clk);
		want <= 5'h17;
		tick(100);
		chk("dac", 32'h17, 32'(dac_code));
		rd(`VST_ADDR_STATUS);
		chk("status", 32'h8, v & 32'hF);
		tick(150);
		@(posedge clk) overload_flag <= 1'b0;
		tick(8);
		chk("mode", 32'h1, 32'(ramp_pulse_mode));
	endtask : t_ovl

	task automatic t_off;
		@(posedge clk) enable_pin <= 1'b0;
		tick(8);
		chk("outs", 32'h0, 32'({high_side_gate_request, low_side_gate_request,
			output_good_oe_n, ramp_pulse_mode}));
		rd(`VST_ADDR_STATE);
		chk("state", 32'h0, 32'(v[21:20]));
		tick(40);
		@(posedge clk) enable_pin <= 1'b1;
		tick(460);
		chk("dac", 32'h17, 32'(dac_code));
	endtask : t_off

	// software-forced pwm overrides ramp-pulse mode while set
	task automatic t_force;
		wr(`VST_ADDR_CTRL, 32'h1);
		tick(1);
		chk("mode", 32'h0, 32'(ramp_pulse_mode));
		rd(`VST_ADDR_CTRL);
		chk("ctrl", 32'h1, v);
		wr(`VST_ADDR_CTRL, 32'h0);
		tick(1);
		chk("mode", 32'h1, 32'(ramp_pulse_mode));
	endtask : t_force

	always #5 clk = ~clk;

	// ramp meets the error level one cycle after the high side rises
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ramp_reached_comp <= high_side_gate_request;
		if (ramp_start === 1'b1) begin
			rs_cnt <= rs_cnt + 1;
		end
		if (cyc == 6000) begin
			bad_count++;
			wrap_up();
		end
	end

	initial begin
		{clk, reg_wr, reg_rd, overload_flag, comp_above_thresh} = 5'h00;
		{rst, enable_pin, supply_ok, vout_above_low, vout_below_high} = 5'h1F;
		{ramp_reached_comp, cyc, rs_cnt, bad_count, tests_run} = '0;
		{reg_addr, reg_wdata, want} = {8'h00, 32'h0, 5'h1C};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_start();
		t_good();
		t_rpm();
		t_move();
		t_ovl();
		t_off();
		t_force();
		wrap_up();
	end
endmodule : vst_sequencer_tb_top
